// ### pcd_pkg.sv
/*
 * pcd_pkg: constants and types for the clock divider block.
 * Assumes 16-bit registers at word addresses on a plain register port.
 */
package pcd_pkg;

   // register addresses
   localparam logic [15:0] PATH_SEL_ADDR = 16'h1C80;
   localparam logic [15:0] MULT_ADDR = 16'h1C88;
   localparam logic [15:0] PRESCALE_ADDR = 16'h1C8A;
   localparam logic [15:0] SYS_ONE_ADDR = 16'h1C8C;
   localparam logic [15:0] SYS_TWO_ADDR = 16'h1C8E;

   // field layout
   localparam int ENABLE_BIT = 15;
   localparam int RATIO_MSB = 4;
   localparam int RATIO_LSB = 0;
   localparam int PATH_BIT = 0;

   // reset values
   localparam logic RST_ENABLE = 1'b1;
   localparam logic [4:0] RST_PRESCALE_RATIO = 5'h00;
   localparam logic [4:0] RST_SYS_RATIO = 5'h03;
   localparam logic RST_PATH_SEL = 1'b0;
   localparam logic [4:0] RST_MULT = 5'h00;

   // legal codes
   localparam logic [4:0] SYS_DIV1 = 5'h00;
   localparam logic [4:0] SYS_DIV2 = 5'h01;
   localparam logic [4:0] SYS_DIV4 = 5'h03;
   localparam logic [4:0] MULT_MIN = 5'h02;
   localparam logic [4:0] MULT_MAX = 5'h0F;

   typedef struct packed {
      logic enable;
      logic [4:0] ratio;
   } pcd_ctrl_type;

   typedef struct packed {
      logic [4:0] cnt;
      logic [4:0] ratio;
      logic tick;
   } pcd_div_type;

endpackage : pcd_pkg

// ### pcd_dividers.sv
/*
 * pcd_dividers: prescaler and two system-clock post-dividers with their
 * control registers. Each divided clock leaves as a one-cycle enable pulse
 * on ref_clk. Assumes pll_tick comes from logic on ref_clk (no sync needed)
 * and that the register master follows the one-cycle strobe protocol.
 */
`timescale 1ns/1ns
`default_nettype none

module pcd_dividers (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rd_data,
   // pll interface
   input wire logic pll_tick,
   output logic pll_path_select,
   output logic [4:0] pll_multiplier_code,
   // divided clock enables
   output logic prescaler_tick,
   output logic first_system_clock,
   output logic second_system_clock
);

   pcd_pkg::pcd_ctrl_type pre_ctrl_r;
   pcd_pkg::pcd_ctrl_type one_ctrl_r;
   pcd_pkg::pcd_ctrl_type two_ctrl_r;
   logic path_sel_r;
   logic [4:0] mult_r;
   logic [15:0] rd_data_r;
   pcd_pkg::pcd_div_type pre_r;
   pcd_pkg::pcd_div_type one_r;
   pcd_pkg::pcd_div_type two_r;
   logic sys_src_tick;
   logic [4:0] wr_ratio;
   logic wr_en_bit;

   assign wr_ratio = reg_wr_data[pcd_pkg::RATIO_MSB:pcd_pkg::RATIO_LSB];
   assign wr_en_bit = reg_wr_data[pcd_pkg::ENABLE_BIT];

   // one divider step; the ratio is reloaded only at the wrap or while disabled so a change
   // never shortens the period that is under way
   function automatic pcd_pkg::pcd_div_type div_step(
      input pcd_pkg::pcd_div_type cur,
      input pcd_pkg::pcd_ctrl_type ctrl,
      input logic src);
      pcd_pkg::pcd_div_type nxt;
      nxt = cur;
      nxt.tick = 1'b0;
      if (!ctrl.enable) begin
         nxt.cnt = 5'h00;
         nxt.ratio = ctrl.ratio;
      end else if (src) begin
         if (cur.cnt >= cur.ratio) begin
            nxt.cnt = 5'h00;
            nxt.tick = 1'b1;
            nxt.ratio = ctrl.ratio;
         end else begin
            nxt.cnt = cur.cnt + 5'h01;
         end
      end
      return nxt;
   endfunction : div_step

   function automatic logic sys_code_ok(input logic [4:0] code);
      return (code == pcd_pkg::SYS_DIV1) || (code == pcd_pkg::SYS_DIV2) ||
             (code == pcd_pkg::SYS_DIV4);
   endfunction : sys_code_ok

   function automatic logic [15:0] ctrl_word(input pcd_pkg::pcd_ctrl_type c);
      return {c.enable, 10'h000, c.ratio};
   endfunction : ctrl_word

   // prescaler control
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pre_ctrl_r.enable <= pcd_pkg::RST_ENABLE;
         pre_ctrl_r.ratio <= pcd_pkg::RST_PRESCALE_RATIO;
      end else if (reg_wr && reg_addr == pcd_pkg::PRESCALE_ADDR) begin
         pre_ctrl_r.enable <= wr_en_bit;
         pre_ctrl_r.ratio <= wr_ratio;
      end
   end

   // first system divider control; reserved ratio codes are not stored
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         one_ctrl_r.enable <= pcd_pkg::RST_ENABLE;
         one_ctrl_r.ratio <= pcd_pkg::RST_SYS_RATIO;
      end else if (reg_wr && reg_addr == pcd_pkg::SYS_ONE_ADDR) begin
         one_ctrl_r.enable <= wr_en_bit;
         if (sys_code_ok(wr_ratio)) begin
            one_ctrl_r.ratio <= wr_ratio;
         end
      end
   end

   // second system divider control
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         two_ctrl_r.enable <= pcd_pkg::RST_ENABLE;
         two_ctrl_r.ratio <= pcd_pkg::RST_SYS_RATIO;
      end else if (reg_wr && reg_addr == pcd_pkg::SYS_TWO_ADDR) begin
         two_ctrl_r.enable <= wr_en_bit;
         if (sys_code_ok(wr_ratio)) begin
            two_ctrl_r.ratio <= wr_ratio;
         end
      end
   end

   // path select and multiplier
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         path_sel_r <= pcd_pkg::RST_PATH_SEL;
         mult_r <= pcd_pkg::RST_MULT;
      end else if (reg_wr) begin
         if (reg_addr == pcd_pkg::PATH_SEL_ADDR) begin
            path_sel_r <= reg_wr_data[pcd_pkg::PATH_BIT];
         end else if (reg_addr == pcd_pkg::MULT_ADDR) begin
            if (wr_ratio >= pcd_pkg::MULT_MIN &&
                wr_ratio <= pcd_pkg::MULT_MAX) begin
               mult_r <= wr_ratio;
            end
         end
      end
   end

   // read port: data stand in the cycle after the strobe only
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_data_r <= 16'h0000;
      end else if (!reg_rd) begin
         rd_data_r <= 16'h0000;
      end else if (reg_addr == pcd_pkg::PRESCALE_ADDR) begin
         rd_data_r <= ctrl_word(pre_ctrl_r);
      end else if (reg_addr == pcd_pkg::SYS_ONE_ADDR) begin
         rd_data_r <= ctrl_word(one_ctrl_r);
      end else if (reg_addr == pcd_pkg::SYS_TWO_ADDR) begin
         rd_data_r <= ctrl_word(two_ctrl_r);
      end else if (reg_addr == pcd_pkg::PATH_SEL_ADDR) begin
         rd_data_r <= {15'h0000, path_sel_r};
      end else if (reg_addr == pcd_pkg::MULT_ADDR) begin
         rd_data_r <= {11'h000, mult_r};
      end else begin
         rd_data_r <= 16'h0000;
      end
   end

   // source mux in front of the post-dividers
   assign sys_src_tick = path_sel_r ? pll_tick : 1'b1;

   // divider counters; every system clock goes through its divider
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pre_r <= '0;
         one_r <= '0;
         two_r <= '0;
      end else begin
         pre_r <= div_step(pre_r, pre_ctrl_r, 1'b1);
         one_r <= div_step(one_r, one_ctrl_r, sys_src_tick);
         two_r <= div_step(two_r, two_ctrl_r, sys_src_tick);
      end
   end

   assign reg_rd_data = rd_data_r;
   assign pll_path_select = path_sel_r;
   assign pll_multiplier_code = mult_r;
   assign prescaler_tick = pre_r.tick;
   assign first_system_clock = one_r.tick;
   assign second_system_clock = two_r.tick;

endmodule : pcd_dividers

`default_nettype wire

// ### pcd_sva.sv
/* pcd_sva: port-level checks for pcd_dividers.
   Bound to every pcd_dividers instance; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module pcd_sva (
   // clock and register port
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rd_data,
   // pll side and divided outputs
   input wire logic pll_tick,
   input wire logic pll_path_select,
   input wire logic [4:0] pll_multiplier_code,
   input wire logic prescaler_tick,
   input wire logic first_system_clock,
   input wire logic second_system_clock
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic off = reg_wr && !reg_wr_data[15];
   wire logic mw = reg_wr && reg_addr == pcd_pkg::MULT_ADDR;
   wire logic mok = reg_wr_data[4:0] >= pcd_pkg::MULT_MIN &&
      reg_wr_data[4:0] <= pcd_pkg::MULT_MAX;
   sequence s_quiet; (pll_path_select && !pll_tick) [*3]; endsequence
   sequence s_off(a); off && reg_addr == a; endsequence
   property p_rsvd; reg_rd |=> reg_rd_data[14:5] == 10'h000; endproperty
   // a pulse already launched may still show in the cycle after the write
   property p_pre; s_off(pcd_pkg::PRESCALE_ADDR) |=> ##1 !prescaler_tick;
   endproperty
   property p_one; s_off(pcd_pkg::SYS_ONE_ADDR) |=> ##1 !first_system_clock;
   endproperty
   property p_two; s_off(pcd_pkg::SYS_TWO_ADDR) |=> ##1 !second_system_clock;
   endproperty
   property p_path; reg_wr && reg_addr == pcd_pkg::PATH_SEL_ADDR |=>
      pll_path_select == $past(reg_wr_data[0]); endproperty
   property p_mult; mw && mok |=>
      pll_multiplier_code == $past(reg_wr_data[4:0]); endproperty
   property p_mhold; mw && !mok |=> $stable(pll_multiplier_code); endproperty
   property p_pll; s_quiet |=> !first_system_clock && !second_system_clock;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits");
   a_pre: assert property (p_pre) else $error("prescaler on");
   a_one: assert property (p_one) else $error("sys one on");
   a_two: assert property (p_two) else $error("sys two on");
   a_path: assert property (p_path) else $error("path");
   a_mult: assert property (p_mult) else $error("mult");
   a_mhold: assert property (p_mhold) else $error("mult kept");
   a_pll: assert property (p_pll) else $error("pll pace");
endmodule : pcd_sva
bind pcd_dividers pcd_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .pll_tick(pll_tick),
   .pll_path_select(pll_path_select),
   .pll_multiplier_code(pll_multiplier_code),
   .prescaler_tick(prescaler_tick), .first_system_clock(first_system_clock),
   .second_system_clock(second_system_clock));
`default_nettype wire

// ### pcd_dividers_bench.sv
/* pcd_dividers_bench: self-checking bench for pcd_dividers.
   Drives every port itself; pcd_sva is bound alongside. */
`timescale 1ns/1ns
`default_nettype none
module pcd_dividers_bench;
   localparam logic [15:0] A0 = pcd_pkg::PRESCALE_ADDR;
   localparam logic [15:0] A1 = pcd_pkg::SYS_ONE_ADDR;
   localparam logic [15:0] A2 = pcd_pkg::SYS_TWO_ADDR;
   localparam logic [15:0] AP = pcd_pkg::PATH_SEL_ADDR;
   localparam logic [15:0] AM = pcd_pkg::MULT_ADDR;
   logic ref_clk, rst_n, reg_wr, reg_rd, pll_tick, rd_seen;
   logic [15:0] reg_addr, reg_wr_data;
   logic [15:0] notes[$];
   // free-running pace counter; only the always block below updates it
   logic [1:0] tc = 2'h0;
   wire logic [15:0] reg_rd_data;
   wire logic [2:0] o;
   wire logic sel;
   wire logic [4:0] mc;
   int errors, total_checks, seed, r, i;
   pcd_dividers dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rd_data(reg_rd_data), .pll_tick(pll_tick), .pll_path_select(sel),
      .pll_multiplier_code(mc), .prescaler_tick(o[0]),
      .first_system_clock(o[1]), .second_system_clock(o[2]));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // pll pulse every fourth cycle leaves three quiet cycles between
   always @(posedge ref_clk) begin
      tc <= tc + 2'h1;
      pll_tick <= tc == 2'h3;
      rd_seen <= reg_rd;
   end
   // read data stand one cycle only, so compare mid-cycle
   always @(negedge ref_clk) begin
      if (rd_seen === 1'b1) chk(reg_rd_data === notes.pop_front());
   end
   task automatic chk(input bit ok);
      total_checks++;
      if (!ok) begin
         errors++;
         $display("unexpected at %0t: mismatch", $time);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      notes.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask : rd
   // gaps are judged only after two pulses: a new ratio waits for the wrap
   task automatic per(input int s, input int e);
      int c, k, l;
      k = 0;
      l = 0;
      for (c = 0; c < 170; c++) begin
         @(negedge ref_clk);
         if (o[s] === 1'b1) begin
            if (k > 1) chk(c - l == e);
            l = c;
            k++;
         end
      end
      chk(e == 0 ? k == 0 : k > 3);
   endtask : per
   task results;
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   initial begin
      seed = 30669;
      {reg_wr, reg_rd, rst_n} = 3'h0;
      reg_addr = 16'h0000;
      reg_wr_data = 16'h0000;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(A0, 16'h8000);
      rd(A1, 16'h8003);
      rd(A2, 16'h8003);
      rd(16'h1C90, 16'h0000);
      per(1, 4);
      wr(A1, 16'hFFE1);
      rd(A1, 16'h8001);
      wr(A1, 16'h8002);
      rd(A1, 16'h8001);
      wr(A2, 16'h801F);
      rd(A2, 16'h8003);
      wr(AM, 16'h000F);
      wr(AM, 16'h0001);
      wr(AM, 16'h0010);
      rd(AM, 16'h000F);
      chk(mc === 5'h0F);
      for (i = 0; i < 5; i++) begin
         r = i == 0 ? 31 : $random(seed) & 31;
         wr(A0, 16'h8000 | r[15:0]);
         per(0, r + 1);
      end
      for (i = 0; i < 6; i++) begin
         r = i % 3 == 2 ? 3 : i % 3;
         wr(AP, 16'(i / 3));
         @(negedge ref_clk);
         chk(sel === 1'(i / 3));
         wr(A1, 16'h8000 | r[15:0]);
         wr(A2, 16'h8000 | r[15:0]);
         per(1, (r + 1) * (i / 3 == 1 ? 4 : 1));
         per(2, (r + 1) * (i / 3 == 1 ? 4 : 1));
      end
      wr(A0, 16'h0000);
      wr(A1, 16'h0003);
      wr(A2, 16'h0003);
      per(0, 0);
      per(1, 0);
      per(2, 0);
      results();
   end
endmodule : pcd_dividers_bench
`default_nettype wire
